// >>> design/cps_cfg.svh
// constants of the configuration memory output sequencer
// included by the package and design modules; definitions only
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

`define CPS_DATA_W         8
`define CPS_REV_W          2
`define CPS_OFF_W          4
`define CPS_ADDR_W         6
`define CPS_NUM_REVS       4
`define CPS_OFF_LAST       4'hf
`define CPS_OFF_ZERO       4'h0
`define CPS_PIN_W          9
`define CPS_PIN_RST        9'h016
`define CPS_CLK_NS         10
`define CPS_OSC_HALF_NS    40
`define CPS_OSC_HALF_CYC   ((`CPS_OSC_HALF_NS) / (`CPS_CLK_NS))
`define CPS_POR_NS         200
`define CPS_POR_CYC        (((`CPS_POR_NS) + (`CPS_CLK_NS) - 1) / (`CPS_CLK_NS))
`define CPS_CF_PULSE_NS    100
`define CPS_CF_PULSE_CYC   (((`CPS_CF_PULSE_NS) + (`CPS_CLK_NS) - 1) / (`CPS_CLK_NS))
`define CPS_CNT_W          8
`define CPS_IR_W           4
`define CPS_IR_CAPTURE     4'h1
`define CPS_IR_BYPASS      4'hf
`define CPS_IR_CONFIG      4'he

`endif

// >>> design/cps_pkg.sv
// types shared by the output sequencer modules
// assumes cps_cfg.svh is on the include path
`include "cps_cfg.svh"

package cps_pkg;

  typedef struct packed {
    logic                  config_clock_out_en;
    logic                  clk_sel_osc;
    logic                  parallel_mode;
    logic                  decompress;
    logic [`CPS_REV_W-1:0] rev_internal;
  } cps_ctl_t;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } cps_tap_state_t;

endpackage : cps_pkg

// >>> design/cps_seq.sv
// output sequencer of a configuration memory: address counter, data and
// clock outputs, busy stall, revision choice, cascade chain enable and the
// test port. assumes pins arrive asynchronously and pull-ups sit outside.
`timescale 1ns/1ps
`include "cps_cfg.svh"

module cps_seq
  import cps_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   tck_in,
  input  wire logic                   tms_in,
  input  wire logic                   tdi_in,
  output logic                        tdo_out,
  output logic                        tdo_oe_n_out,
  input  wire cps_ctl_t               ctl_in,
  input  wire logic [`CPS_NUM_REVS-1:0] rev_present_in,
  input  wire logic                   prog_we_in,
  input  wire logic [`CPS_ADDR_W-1:0] prog_addr_in,
  input  wire logic [`CPS_DATA_W-1:0] prog_data_in,
  input  wire logic                   decomp_ready_in,
  input  wire logic                   cfg_clk_in,
  input  wire logic                   chip_enable_n_in,
  input  wire logic                   oe_reset_in,
  output logic                        oe_reset_out,
  output logic                        oe_reset_oe_n_out,
  input  wire logic                   busy_in,
  input  wire logic                   external_rev_choice_enable_in,
  input  wire logic                   revision_pick_0_in,
  input  wire logic                   revision_pick_1_in,
  input  wire logic                   config_pulse_n_in,
  output logic                        config_pulse_n_out,
  output logic                        config_pulse_n_oe_n_out,
  output logic [`CPS_DATA_W-1:0]      data_out,
  output logic                        data_oe_n_out,
  output logic                        config_clock_out,
  output logic                        config_clock_oe_n_out,
  output logic                        chain_enable_out_n_out,
  output logic [`CPS_OFF_W-1:0]       addr_offset_out,
  output logic                        terminal_count_out
);

  // storage of the revisions, one block of words each
  logic [`CPS_DATA_W-1:0] mem_q [0:(1 << `CPS_ADDR_W)-1];

  // test clock domain
  logic                   tck_rst;
  logic                   cfg_req_tgl;

  cps_sync3 #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_tck_rst (
    .clk_in   (tck_in),
    .rst_in   (1'b0),
    .async_in (rst_in),
    .sync_out (tck_rst)
  );

  cps_tap u_tap (
    .tck_in          (tck_in),
    .rst_in          (tck_rst),
    .tms_in          (tms_in),
    .tdi_in          (tdi_in),
    .tdo_out         (tdo_out),
    .tdo_oe_n_out    (tdo_oe_n_out),
    .cfg_req_tgl_out (cfg_req_tgl)
  );

  // pin and cross-domain inputs
  logic [`CPS_PIN_W-1:0]  pins_raw;
  logic [`CPS_PIN_W-1:0]  pins_s;
  logic                   cfg_clk_s;
  logic                   ce_n_s;
  logic                   oe_rst_s;
  logic                   busy_s;
  logic                   ext_en_s;
  logic [`CPS_REV_W-1:0]  rev_pins_s;
  logic                   cf_n_s;
  logic                   req_tgl_s;

  assign pins_raw = {cfg_req_tgl, config_pulse_n_in, revision_pick_1_in, revision_pick_0_in,
                     external_rev_choice_enable_in, busy_in, oe_reset_in, chip_enable_n_in,
                     cfg_clk_in};

  cps_sync3 #(
    .W       (`CPS_PIN_W),
    .RST_VAL (`CPS_PIN_RST)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign cfg_clk_s  = pins_s[0];
  assign ce_n_s     = pins_s[1];
  assign oe_rst_s   = pins_s[2];
  assign busy_s     = pins_s[3];
  assign ext_en_s   = pins_s[4];
  assign rev_pins_s = pins_s[6:5];
  assign cf_n_s     = pins_s[7];
  assign req_tgl_s  = pins_s[8];

  // registers
  logic [`CPS_CNT_W-1:0]  osc_cnt_q;
  logic                   osc_q;
  logic                   src_prev_q;
  logic                   cf_prev_q;
  logic                   req_prev_q;
  logic [`CPS_CNT_W-1:0]  por_cnt_q;
  logic [`CPS_CNT_W-1:0]  cf_cnt_q;
  logic [`CPS_REV_W-1:0]  rev_q;
  logic [`CPS_OFF_W-1:0]  off_q;
  logic                   tc_q;
  logic [`CPS_DATA_W-1:0] data_q;
  logic                   data_oe_n_q;
  logic                   clk_out_q;
  logic                   clk_oe_n_q;
  logic                   ceo_n_q;

  // decoding
  logic                   osc_wrap;
  logic                   src_lvl;
  logic                   src_rise;
  logic                   por_busy;
  logic                   enabled;
  logic                   active;
  logic                   data_avail;
  logic                   busy_stall;
  logic                   cf_rise;
  logic                   cf_req;
  logic [`CPS_REV_W-1:0]  rev_now;
  logic                   advance;
  logic [`CPS_ADDR_W-1:0] rd_addr;
  logic                   rev_empty;
  logic                   clk_park;

  assign osc_wrap   = (osc_cnt_q == `CPS_CNT_W'(`CPS_OSC_HALF_CYC - 1));
  assign src_lvl    = ctl_in.clk_sel_osc ? osc_q : cfg_clk_s;
  assign src_rise   = src_lvl & ~src_prev_q;
  assign por_busy   = (por_cnt_q != '0);
  assign enabled    = ~ce_n_s & oe_rst_s;
  assign active     = enabled & ~por_busy;
  assign data_avail = ~ctl_in.decompress | decomp_ready_in;
  // busy only counts in uncompressed parallel mode
  assign busy_stall = ctl_in.parallel_mode & ~ctl_in.decompress & busy_s;
  assign cf_rise    = cf_n_s & ~cf_prev_q;
  assign cf_req     = req_tgl_s ^ req_prev_q;
  // pins win when the external choice is enabled low
  assign rev_now    = ext_en_s ? ctl_in.rev_internal : rev_pins_s;
  assign advance    = src_rise & active & data_avail & ~busy_stall & cf_n_s & ~tc_q;
  assign rd_addr    = {rev_q, off_q};
  assign rev_empty  = ~rev_present_in[rev_q];
  assign clk_park   = ctl_in.decompress & ~decomp_ready_in;

  // internal oscillator from the system clock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      osc_cnt_q <= '0;
      osc_q     <= 1'b0;
    end
    else
    begin
      osc_cnt_q <= osc_wrap ? '0 : osc_cnt_q + 1'b1;
      if (osc_wrap)
        osc_q <= ~osc_q;
    end
  end

  // edge memories
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      src_prev_q <= 1'b0;
      cf_prev_q  <= 1'b1;
      req_prev_q <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_lvl;
      cf_prev_q  <= cf_n_s;
      req_prev_q <= req_tgl_s;
    end
  end

  // power-on hold of the output-enable/reset pin
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      por_cnt_q <= `CPS_CNT_W'(`CPS_POR_CYC);
    else if (por_busy)
      por_cnt_q <= por_cnt_q - 1'b1;
  end

  // configuration pulse driven low on test port request
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cf_cnt_q <= '0;
    else if (cf_req)
      cf_cnt_q <= `CPS_CNT_W'(`CPS_CF_PULSE_CYC);
    else if (cf_cnt_q != '0)
      cf_cnt_q <= cf_cnt_q - 1'b1;
  end

  // revision latch and address counter
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rev_q <= '0;
      off_q <= `CPS_OFF_ZERO;
      tc_q  <= 1'b0;
    end
    else if (cf_rise)
    begin
      rev_q <= rev_now;
      off_q <= `CPS_OFF_ZERO;
      tc_q  <= 1'b0;
    end
    else if (!active)
    begin
      off_q <= `CPS_OFF_ZERO;
      tc_q  <= 1'b0;
    end
    else if (advance)
    begin
      if (off_q == `CPS_OFF_LAST)
        tc_q <= 1'b1;
      else
        off_q <= off_q + 1'b1;
    end
  end

  // data word follows each advance and holds otherwise
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      data_q <= '0;
    else if (advance)
      data_q <= mem_q[rd_addr];
  end

  // stored words are written from the programming port
  always_ff @(posedge clk_in)
  begin
    if (prog_we_in)
      mem_q[prog_addr_in] <= prog_data_in;
  end

  // output pins
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      data_oe_n_q <= 1'b1;
      clk_out_q   <= 1'b1;
      clk_oe_n_q  <= 1'b1;
      ceo_n_q     <= 1'b1;
    end
    else
    begin
      data_oe_n_q <= ~active;
      // clock rises in the same cycle the new word is loaded
      clk_out_q   <= clk_park | src_lvl;
      clk_oe_n_q  <= ~(active & ctl_in.config_clock_out_en);
      ceo_n_q     <= ~(enabled & (tc_q | rev_empty));
    end
  end

  assign data_out                = data_q;
  assign data_oe_n_out           = data_oe_n_q;
  assign config_clock_out        = clk_out_q;
  assign config_clock_oe_n_out   = clk_oe_n_q;
  assign chain_enable_out_n_out  = ceo_n_q;
  assign oe_reset_out            = 1'b0;
  assign oe_reset_oe_n_out       = ~por_busy;
  assign config_pulse_n_out      = 1'b0;
  assign config_pulse_n_oe_n_out = (cf_cnt_q == '0);
  assign addr_offset_out         = off_q;
  assign terminal_count_out      = tc_q;

endmodule : cps_seq

// >>> design/cps_sync3.sv
// three-flop synchroniser; output changes once stages two and three agree
// assumes the destination clock samples asynchronous levels
`timescale 1ns/1ps
`include "cps_cfg.svh"

module cps_sync3
  import cps_pkg::*;
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;

  // per bit: take stage two only where it matches stage three
  assign out_d = (s2_q & ~(s2_q ^ s3_q)) | (sync_out & (s2_q ^ s3_q));

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1_q     <= RST_VAL;
      s2_q     <= RST_VAL;
      s3_q     <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      sync_out <= out_d;
    end
  end

endmodule : cps_sync3

// >>> design/cps_tap.sv
// test access port controller with instruction register and bypass
// runs on the test clock; reset arrives already synchronised to it
`timescale 1ns/1ps
`include "cps_cfg.svh"

module cps_tap
  import cps_pkg::*;
(
  input  wire logic tck_in,
  input  wire logic rst_in,
  input  wire logic tms_in,
  input  wire logic tdi_in,
  output logic      tdo_out,
  output logic      tdo_oe_n_out,
  output logic      cfg_req_tgl_out
);

  cps_tap_state_t         state_q;
  cps_tap_state_t         state_d;
  logic [`CPS_IR_W-1:0]   ir_sh_q;
  logic [`CPS_IR_W-1:0]   ir_q;
  logic                   byp_q;
  logic                   tdo_d;
  logic                   shifting;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      TAP_RESET:    state_d = tms_in ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   state_d = tms_in ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_d = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   state_d = tms_in ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_d = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
      default:      state_d = TAP_RESET;
    endcase
  end

  assign shifting = (state_q == TAP_SHIFT_DR) || (state_q == TAP_SHIFT_IR);
  assign tdo_d    = (state_q == TAP_SHIFT_IR) ? ir_sh_q[0] : byp_q;

  always_ff @(posedge tck_in)
  begin
    if (rst_in)
    begin
      state_q         <= TAP_RESET;
      ir_sh_q         <= `CPS_IR_CAPTURE;
      ir_q            <= `CPS_IR_BYPASS;
      byp_q           <= 1'b0;
      cfg_req_tgl_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == TAP_RESET)
        ir_q <= `CPS_IR_BYPASS;
      if (state_q == TAP_CAP_IR)
        ir_sh_q <= `CPS_IR_CAPTURE;
      else if (state_q == TAP_SHIFT_IR)
        ir_sh_q <= {tdi_in, ir_sh_q[`CPS_IR_W-1:1]};
      if (state_q == TAP_CAP_DR)
        byp_q <= 1'b0;
      else if (state_q == TAP_SHIFT_DR)
        byp_q <= tdi_in;
      if (state_q == TAP_UPD_IR)
      begin
        ir_q <= ir_sh_q;
        // config instruction requests a configuration pulse
        if (ir_sh_q == `CPS_IR_CONFIG)
          cfg_req_tgl_out <= ~cfg_req_tgl_out;
      end
    end
  end

  // output changes on the falling test clock edge
  always_ff @(negedge tck_in)
  begin
    if (rst_in)
    begin
      tdo_out      <= 1'b1;
      tdo_oe_n_out <= 1'b1;
    end
    else
    begin
      tdo_out      <= tdo_d;
      tdo_oe_n_out <= ~shifting;
    end
  end

endmodule : cps_tap

// >>> sim/cps_fpga_model.sv
// receiving logic device: makes configuration clock bursts, drives busy,
// captures words; assumes clk_in is the sequencer's system clock
`timescale 1ns/1ps
`include "cps_cfg.svh"

module cps_fpga_model
  import cps_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   stall_in,
  input  wire logic                   chain_n_in,
  input  wire logic                   cclk_in,
  input  wire logic                   cclk_oe_n_in,
  input  wire logic [`CPS_DATA_W-1:0] data_in,
  output logic                        cfg_clk_out,
  output logic                        busy_out,
  output logic                        next_sel_n_out
);
  logic [`CPS_DATA_W-1:0] words [16];
  int                     n_words;
  logic                   cclk_q;

  assign busy_out       = stall_in;
  assign next_sel_n_out = chain_n_in;

  initial
  begin
    cfg_clk_out = 1'b0;
    n_words     = 0;
    cclk_q      = 1'b1;
  end

  // take the word one edge after the clock output rise, once settled
  always @(posedge clk_in)
  begin
    cclk_q <= cclk_in;
    if (cclk_in && !cclk_q && !cclk_oe_n_in)
    begin
      words[n_words % 16] <= data_in;
      n_words             <= n_words + 1;
    end
  end

  // clock stands low between bursts
  task automatic burst(input int n);
    repeat (n)
    begin
      #60 cfg_clk_out = 1'b1;
      #60 cfg_clk_out = 1'b0;
    end
  endtask : burst
endmodule : cps_fpga_model

// >>> sim/cps_seq_checker.sv
// concurrent checks on the output sequencer ports
// bound to cps_seq; pins are asynchronous, so waits cover the synchroniser
`timescale 1ns/1ps
`include "cps_cfg.svh"

module cps_seq_checker
  import cps_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   rst_in,
  input wire cps_ctl_t               ctl_in,
  input wire logic                   decomp_ready_in,
  input wire logic                   chip_enable_n_in,
  input wire logic                   oe_reset_in,
  input wire logic                   busy_in,
  input wire logic [`CPS_DATA_W-1:0] data_out,
  input wire logic                   data_oe_n_out,
  input wire logic                   config_clock_out,
  input wire logic                   config_clock_oe_n_out,
  input wire logic                   chain_enable_out_n_out,
  input wire logic [`CPS_OFF_W-1:0]  addr_offset_out,
  input wire logic                   terminal_count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic stall = ctl_in.parallel_mode & ~ctl_in.decompress & busy_in;

  a_chain_off_ce:
    assert property (chip_enable_n_in [*7] |-> chain_enable_out_n_out) else $error("chain enable low while off");
  a_chain_low_tc:
    assert property ((!chip_enable_n_in && oe_reset_in && terminal_count_out) [*7] |-> !chain_enable_out_n_out)
      else $error("chain enable high after last word");
  a_float_oe_low:
    assert property ((!oe_reset_in) [*7] |-> data_oe_n_out && config_clock_oe_n_out && addr_offset_out == 4'h0
      && !terminal_count_out) else $error("outputs active while output enable low");
  a_float_ce_high:
    assert property (chip_enable_n_in [*7] |-> data_oe_n_out && config_clock_oe_n_out && addr_offset_out == 4'h0)
      else $error("outputs active while deselected");
  a_busy_freeze:
    assert property (stall [*7] |=> $stable(addr_offset_out) && $stable(data_out)) else $error("moved during busy");
  a_clk_enable:
    assert property ((!ctl_in.config_clock_out_en) [*2] |-> config_clock_oe_n_out) else $error("clock output on while off");
  a_park_high:
    assert property ((ctl_in.decompress && !decomp_ready_in) [*2] |-> config_clock_out)
      else $error("clock output not parked high");
  a_step_at_rise:
    assert property (($changed(addr_offset_out) && addr_offset_out != 4'h0) |-> $rose(config_clock_out))
      else $error("address stepped without clock rise");
  a_tc_hold:
    assert property ((terminal_count_out && $past(terminal_count_out)) |-> $stable(addr_offset_out))
      else $error("address moved past last word");

  c_tc: cover property ($rose(terminal_count_out));
  c_stall: cover property (stall [*7]);
  c_chain: cover property ($fell(chain_enable_out_n_out));
  c_clk_on: cover property ($fell(config_clock_oe_n_out));
endmodule : cps_seq_checker

bind cps_seq cps_seq_checker chk (.clk_in(clk_in), .rst_in(rst_in), .ctl_in(ctl_in),
  .decomp_ready_in(decomp_ready_in), .chip_enable_n_in(chip_enable_n_in), .oe_reset_in(oe_reset_in),
  .busy_in(busy_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out), .config_clock_out(config_clock_out),
  .config_clock_oe_n_out(config_clock_oe_n_out), .chain_enable_out_n_out(chain_enable_out_n_out),
  .addr_offset_out(addr_offset_out), .terminal_count_out(terminal_count_out));

// >>> sim/testbench.sv
// self-checking bench for the output sequencer
// assumes cps_seq, its checker bind and the device-side model are compiled
`timescale 1ns/1ps
`include "cps_cfg.svh"

module testbench
  import cps_pkg::*;
;
  logic clk, rst, tck, tms, tdi, pwe, rdy, ce_n, oe_drv, ext_en, pk0, pk1, cf_drv, stall;
  logic tdo, tdo_oe_n, oe_o, oe_oe_n, cf_o, cf_oe_n, cclk, cclk_oe_n, chain_n, tc, cfg_clk, busy, next_n, d_oe_n;
  cps_ctl_t               ctl;
  logic [`CPS_ADDR_W-1:0] paddr;
  logic [`CPS_DATA_W-1:0] pdata, dout, d0;
  logic [`CPS_OFF_W-1:0]  off;
  logic [3:0]             present;
  int                     n_mismatch, checks;
  // open-drain pins with pull-ups
  wire logic oe_w = oe_drv & (oe_oe_n | oe_o);
  wire logic cf_w = cf_drv & (cf_oe_n | cf_o);

  cps_seq uut (.clk_in(clk), .rst_in(rst), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_n_out(tdo_oe_n), .ctl_in(ctl), .rev_present_in(present), .prog_we_in(pwe), .prog_addr_in(paddr),
    .prog_data_in(pdata), .decomp_ready_in(rdy), .cfg_clk_in(cfg_clk), .chip_enable_n_in(ce_n),
    .oe_reset_in(oe_w), .oe_reset_out(oe_o), .oe_reset_oe_n_out(oe_oe_n), .busy_in(busy),
    .external_rev_choice_enable_in(ext_en), .revision_pick_0_in(pk0), .revision_pick_1_in(pk1),
    .config_pulse_n_in(cf_w), .config_pulse_n_out(cf_o), .config_pulse_n_oe_n_out(cf_oe_n), .data_out(dout),
    .data_oe_n_out(d_oe_n), .config_clock_out(cclk), .config_clock_oe_n_out(cclk_oe_n),
    .chain_enable_out_n_out(chain_n), .addr_offset_out(off), .terminal_count_out(tc));

  cps_fpga_model partner (.clk_in(clk), .stall_in(stall), .chain_n_in(chain_n), .cclk_in(cclk),
    .cclk_oe_n_in(cclk_oe_n), .data_in(dout), .cfg_clk_out(cfg_clk), .busy_out(busy), .next_sel_n_out(next_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    tck = 1'b0;
    #7;
    forever #15 tck = ~tck;
  end

  function automatic logic [7:0] fpat(input int a);
    return 8'(a * 7 + 3);
  endfunction : fpat

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic pulse_cf;
    cf_drv = 1'b0;
    cyc(12);
    cf_drv = 1'b1;
    cyc(10);
  endtask : pulse_cf

  task automatic tap(input logic m, input logic d, output logic o);
    @(negedge tck);
    tms = m;
    tdi = d;
    @(posedge tck);
    o = tdo;
  endtask : tap

  initial
  begin
    #100us;
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end

  initial
  begin
    logic [3:0] ir;
    logic       o;
    int         i;
    rst = 1'b1; tms = 1'b1; tdi = 1'b1; pwe = 1'b0; paddr = '0; pdata = '0; rdy = 1'b1; ce_n = 1'b1;
    oe_drv = 1'b1; ext_en = 1'b1; pk0 = 1'b1; pk1 = 1'b1; cf_drv = 1'b1; stall = 1'b0;
    n_mismatch = 0; checks = 0; present = 4'h7;
    ctl = '{config_clock_out_en: 1'b1, clk_sel_osc: 1'b0, parallel_mode: 1'b0, decompress: 1'b0, rev_internal: 2'h0};
    cyc(12);
    rst = 1'b0;
    cyc(30);
    for (i = 0; i < 64; i++)
    begin
      pwe = 1'b1; paddr = 6'(i); pdata = fpat(i);
      cyc(1);
    end
    pwe = 1'b0;
    // revision two from pins, full stream into cascade hand-over
    ext_en = 1'b0; pk0 = 1'b0; ce_n = 1'b0;
    cyc(8);
    pulse_cf();
    partner.burst(16);
    cyc(8);
    for (i = 0; i < 16; i++) check(partner.words[i], fpat(32 + i), "word");
    check(8'(partner.n_words), 8'h10, "word count");
    check(tc, 1'b1, "terminal count");
    check(chain_n, 1'b0, "chain enable");
    check(next_n, 1'b0, "next select");
    $display("test stream done");
    ce_n = 1'b1;
    cyc(8);
    check({chain_n, d_oe_n, cclk_oe_n, off}, {3'h7, 4'h0}, "deselected");
    ce_n = 1'b0; oe_drv = 1'b0;
    cyc(8);
    check({chain_n, d_oe_n, off}, {2'h3, 4'h0}, "output enable low");
    oe_drv = 1'b1;
    cyc(8);
    check(chain_n, 1'b1, "chain after reset");
    $display("test disable done");
    ext_en = 1'b1; ctl.rev_internal = 2'h3;
    pulse_cf();
    check({chain_n, tc}, 2'h0, "empty revision");
    present = 4'hb; ext_en = 1'b0;
    pulse_cf();
    check(chain_n, 1'b0, "pin revision two");
    pk1 = 1'b0; pk0 = 1'b1;
    pulse_cf();
    check(chain_n, 1'b1, "pin revision one");
    present = 4'hf; ext_en = 1'b1;
    $display("test empty done");
    ctl.rev_internal = 2'h1; ctl.parallel_mode = 1'b1;
    pulse_cf();
    partner.burst(1);
    cyc(2);
    check(off, 4'h1, "offset");
    d0 = dout;
    stall = 1'b1;
    cyc(8);
    partner.burst(3);
    cyc(2);
    check({off, dout}, {4'h1, d0}, "busy hold");
    stall = 1'b0;
    cyc(8);
    partner.burst(1);
    cyc(2);
    check({off, dout}, {4'h2, fpat(17)}, "after busy");
    stall = 1'b1; ctl.parallel_mode = 1'b0;
    cyc(8);
    partner.burst(1);
    ctl.parallel_mode = 1'b1; ctl.decompress = 1'b1;
    partner.burst(1);
    cyc(2);
    check({off, dout}, {4'h4, fpat(19)}, "busy ignored");
    rdy = 1'b0;
    cyc(4);
    check(cclk, 1'b1, "parked clock");
    partner.burst(1);
    cyc(2);
    check(off, 4'h4, "no ready word");
    rdy = 1'b1; stall = 1'b0; ctl.decompress = 1'b0; ctl.parallel_mode = 1'b0;
    $display("test busy done");
    ctl.config_clock_out_en = 1'b0; ctl.clk_sel_osc = 1'b1;
    cyc(20);
    check({cclk_oe_n, 1'(off == 4'h4)}, 2'h2, "oscillator");
    ctl.config_clock_out_en = 1'b1;
    cyc(3);
    check(cclk_oe_n, 1'b0, "clock output on");
    ctl.clk_sel_osc = 1'b0;
    $display("test oscillator done");
    repeat (5) tap(1'b1, 1'b1, o);
    tap(1'b0, 1'b1, o); tap(1'b1, 1'b1, o); tap(1'b1, 1'b1, o); tap(1'b0, 1'b1, o); tap(1'b0, 1'b1, o);
    for (i = 0; i < 4; i++)
    begin
      tap(1'(i == 3), 1'(i != 0), o);
      ir[i] = o;
      check(tdo_oe_n, 1'b0, "test output enable");
    end
    check(ir, 4'h1, "captured instruction");
    tap(1'b1, 1'b1, o); tap(1'b0, 1'b1, o);
    i = 0;
    while (cf_oe_n !== 1'b0 && i < 80)
    begin
      cyc(1);
      i++;
    end
    check(cf_oe_n, 1'b0, "config pulse");
    cyc(20);
    check({off, tc}, 5'h0, "restart");
    $display("test test port done");
    test_done();
  end
endmodule : testbench
